// ===== logic/pmc_pkg.sv
// Purpose: shared constants and types for the power mode and power-on reset controller
// Assumes: 100 MHz system clock, apb register access with 32-bit data
// Notes:   supply thresholds arrive as comparator levels from the analog side
package pmc_pkg;

  localparam logic [7:0] PMC_CTRL_OFS   = 8'h00;
  localparam logic [7:0] PMC_STAT_OFS   = 8'h04;
  localparam logic [7:0] PMC_IRQ_OFS    = 8'h08;
  localparam logic [7:0] PMC_MASK_OFS   = 8'h0c;
  localparam logic [7:0] PMC_ANALOG_OFS = 8'h10;

  // control register fields
  localparam int CTRL_IDLE_BIT   = 0;
  localparam int CTRL_PDOWN_BIT  = 1;
  localparam int CTRL_SERWK_BIT  = 2;
  localparam int CTRL_INT0WK_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // analog enable fields
  localparam int ANA_ADC_BIT  = 0;
  localparam int ANA_DAC0_BIT = 1;
  localparam int ANA_DAC1_BIT = 2;
  localparam int ANA_VREF_BIT = 3;
  localparam logic [3:0] ANA_RESET = 4'h0;

  // sticky event bits
  localparam int EV_IDLE_WAKE  = 0;
  localparam int EV_PD_WAKE    = 1;
  localparam int EV_EXT_RESET  = 2;
  localparam int EV_POR        = 3;
  localparam int EV_NUM        = 4;
  localparam logic [EV_NUM-1:0] EV_RESET = 4'h0;

  // timing
  localparam int CLK_MHZ       = 100;
  localparam int XTAL_MHZ      = 16;
  localparam int POR_DELAY_MS  = 128;
  // counted in crystal ticks, so a slower crystal stretches the delay
  localparam int POR_CYCLES    = POR_DELAY_MS * 1000 * XTAL_MHZ;
  localparam int OSC_SETTLE_US = 10;
  localparam int OSC_CYCLES    = OSC_SETTLE_US * CLK_MHZ;

  typedef enum logic [2:0] {
    PMC_RUN,
    PMC_IDLE,
    PMC_PDOWN,
    PMC_SETTLE
  } pmc_mode_t;

  typedef struct packed {
    logic interval;
    logic serial;
    logic ext_zero;
    logic any_enabled;
  } pmc_irq_t;

  typedef struct packed {
    logic adc_en;
    logic dac0_en;
    logic dac1_en;
    logic vref_en;
  } pmc_analog_t;

endpackage

// ===== logic/pmc_sync.sv
// Purpose: two-stage synchroniser for a vector of asynchronous levels
// Assumes: inputs are levels that stay put for several clocks
// Notes:   first stage feeds only the second
module pmc_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// ===== logic/pmc_por.sv
// Purpose: power-on reset timer driven by supply comparator levels
// Assumes: above and floor levels already synchronised
// Notes:   count width sized for the longest timeout
module pmc_por
  import pmc_pkg::*;
#(
  parameter int POR_COUNT = POR_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic above_thr,
  input  wire logic above_floor,
  input  wire logic osc_tick,
  output logic      por_hold
);
  logic [31:0] cnt_r;
  logic        tick_d_r;
  logic        tick_rise;

  // count tick edges so the delay does not depend on the tick duty cycle
  assign tick_rise = osc_tick && !tick_d_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_d_r <= 1'b0;
    end else begin
      tick_d_r <= osc_tick;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r    <= 32'h0;
      por_hold <= 1'b1;
    end else if (!above_thr || !above_floor) begin
      // held all the way down, so the full delay reruns on the next rise
      cnt_r    <= 32'h0;
      por_hold <= 1'b1;
    end else if (por_hold && tick_rise) begin
      // slower crystal gives fewer ticks, so the delay stretches
      if (cnt_r >= 32'(POR_COUNT - 1)) begin
        por_hold <= 1'b0;
      end else begin
        cnt_r <= cnt_r + 32'h1;
      end
    end
  end
endmodule

// ===== logic/pmc_top.sv
// Purpose: power mode controller with idle, power-down and power-on reset
// Assumes: apb slave on clock, wake and reset pins are asynchronous
// Notes:   analog and port outputs are control levels for the pads
//
// Functional notes
// - software command enters idle or full power-down from normal mode
// - idle keeps oscillator running, gates clock to core only
// - idle keeps peripherals clocked; pins and analog outputs hold
// - any enabled interrupt or hardware reset ends idle
// - power-down stops oscillator and shuts all peripherals
// - power-down keeps port levels, analog outputs go high impedance
// - reset pin in power-down returns normal, defaults, vector after release
// - power cycle loads defaults, reset vector about 128 ms later
// - interval counter interrupt ends power-down and is serviced
// - return from interrupt resumes after the power-down entry instruction
// - serial interrupt wakes power-down only with serial wake enable set
// - external interrupt zero wakes only with its wake enable set
// - power-on reset holds chip while supply below threshold
// - timer runs about 128 ms at 16 MHz; longer at slower crystals, shorter at faster ones
// - on falling supply reset stays asserted until below 1 V
// - software disables converter, each output converter and reference
//
// The register addresses and the APB register port were decided locally.
module pmc_top
  import pmc_pkg::*;
#(
  parameter int POR_COUNT = POR_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_reset_n,
  input  wire logic        supply_above_thr,
  input  wire logic        supply_above_floor,
  input  wire logic        osc_tick,
  input  wire logic        interval_counter,
  input  wire logic        serial_irq,
  input  wire logic        external_interrupt_zero,
  input  wire logic        irq_enabled_any,
  input  wire logic        return_from_interrupt,
  output logic             core_clk_en,
  output logic             periph_clk_en,
  output logic             osc_en,
  output logic             pin_hold,
  output logic             analog_out_hiz,
  output logic             chip_reset,
  output logic             resume_after_pd,
  output pmc_analog_t      analog_en,
  output logic             irq
);

  logic [4:0] async_q;
  logic       rst_pin_s;
  logic       thr_s;
  logic       floor_s;
  logic       external_interrupt_zero_s;
  logic       tick_s;
  logic       por_hold;

  pmc_sync #(.W(5)) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     ({~ext_reset_n, supply_above_thr, supply_above_floor,
             external_interrupt_zero, osc_tick}),
    .q     (async_q)
  );
  assign rst_pin_s = async_q[4];
  assign thr_s     = async_q[3];
  assign floor_s   = async_q[2];
  assign external_interrupt_zero_s    = async_q[1];
  assign tick_s    = async_q[0];

  pmc_por #(.POR_COUNT(POR_COUNT)) u_por (
    .clock       (clock),
    .rst_n       (rst_n),
    .above_thr   (thr_s),
    .above_floor (floor_s),
    .osc_tick    (tick_s),
    .por_hold    (por_hold)
  );

  // soft reset covers the control, analog, mask, mode and resume registers when the pin or power-on reset is active
  logic soft_rst;
  assign soft_rst = por_hold || rst_pin_s;

  logic [3:0]        ctrl_r;
  logic [3:0]        ana_r;
  logic [EV_NUM-1:0] stat_r;
  logic [EV_NUM-1:0] mask_r;
  pmc_mode_t         mode_r;
  logic [15:0]       settle_r;
  logic              resume_r;
  logic              rst_pin_d_r;
  logic              por_d_r;

  logic wr_en;
  logic rd_en;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  pmc_irq_t src;
  assign src.interval    = interval_counter;
  assign src.serial      = serial_irq;
  assign src.ext_zero    = external_interrupt_zero_s;
  assign src.any_enabled = irq_enabled_any;

  logic pd_wake;
  logic idle_wake;
  assign pd_wake = src.interval
                   || (src.serial && ctrl_r[CTRL_SERWK_BIT])
                   || (src.ext_zero && ctrl_r[CTRL_INT0WK_BIT]);
  assign idle_wake = src.any_enabled;

  // control register; mode request bits self-clear on entry
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RESET;
    end else if (soft_rst) begin
      ctrl_r <= CTRL_RESET;
    end else if (wr_en && paddr == PMC_CTRL_OFS) begin
      ctrl_r <= pwdata[3:0];
    end else if (mode_r != PMC_RUN) begin
      ctrl_r[CTRL_IDLE_BIT]  <= 1'b0;
      ctrl_r[CTRL_PDOWN_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ana_r <= ANA_RESET;
    end else if (soft_rst) begin
      ana_r <= ANA_RESET;
    end else if (wr_en && paddr == PMC_ANALOG_OFS) begin
      ana_r <= pwdata[3:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= EV_RESET;
    end else if (soft_rst) begin
      mask_r <= EV_RESET;
    end else if (wr_en && paddr == PMC_MASK_OFS) begin
      mask_r <= pwdata[EV_NUM-1:0];
    end
  end

  // power mode state machine
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_r   <= PMC_RUN;
      settle_r <= 16'h0;
    end else if (soft_rst) begin
      mode_r   <= PMC_RUN;
      settle_r <= 16'h0;
    end else begin
      case (mode_r)
        PMC_RUN: begin
          if (ctrl_r[CTRL_PDOWN_BIT]) begin
            mode_r <= PMC_PDOWN;
          end else if (ctrl_r[CTRL_IDLE_BIT]) begin
            mode_r <= PMC_IDLE;
          end
        end
        PMC_IDLE: begin
          if (idle_wake) begin
            mode_r <= PMC_RUN;
          end
        end
        PMC_PDOWN: begin
          if (pd_wake) begin
            mode_r   <= PMC_SETTLE;
            settle_r <= 16'h0;
          end
        end
        PMC_SETTLE: begin
          // core stays gated until the restarted oscillator is stable
          if (settle_r >= 16'(OSC_CYCLES - 1)) begin
            mode_r <= PMC_RUN;
          end else begin
            settle_r <= settle_r + 16'h1;
          end
        end
        default: mode_r <= PMC_RUN;
      endcase
    end
  end

  // resume marker: core returns past the entry instruction after the handler
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      resume_r <= 1'b0;
    end else if (soft_rst) begin
      resume_r <= 1'b0;
    end else if (mode_r == PMC_SETTLE && settle_r >= 16'(OSC_CYCLES - 1)) begin
      resume_r <= 1'b1;
    end else if (return_from_interrupt) begin
      resume_r <= 1'b0;
    end
  end

  // event edges
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_pin_d_r <= 1'b0;
      por_d_r     <= 1'b1;
    end else begin
      rst_pin_d_r <= rst_pin_s;
      por_d_r     <= por_hold;
    end
  end

  logic [EV_NUM-1:0] ev;
  always_comb begin
    ev               = '0;
    ev[EV_IDLE_WAKE] = (mode_r == PMC_IDLE) && idle_wake;
    ev[EV_PD_WAKE]   = (mode_r == PMC_PDOWN) && pd_wake;
    ev[EV_EXT_RESET] = rst_pin_d_r && !rst_pin_s;
    ev[EV_POR]       = por_d_r && !por_hold;
  end

  logic stat_rd;
  assign stat_rd = rd_en && paddr == PMC_IRQ_OFS;

  // read clears, but a same-cycle event survives
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stat_r <= EV_RESET;
    end else begin
      stat_r <= (stat_rd ? EV_RESET : stat_r) | ev;
    end
  end

  assign irq = |(stat_r & mask_r);

  // apb read data
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == PMC_CTRL_OFS) begin
        prdata <= {28'h0, ctrl_r};
      end else if (paddr == PMC_STAT_OFS) begin
        prdata <= {27'h0, resume_r, 1'b0, 3'(mode_r)};
      end else if (paddr == PMC_IRQ_OFS) begin
        prdata <= {28'h0, stat_r};
      end else if (paddr == PMC_MASK_OFS) begin
        prdata <= {28'h0, mask_r};
      end else if (paddr == PMC_ANALOG_OFS) begin
        prdata <= {28'h0, ana_r};
      end else begin
        prdata <= 32'h0;
      end
    end
  end

  logic addr_ok;
  assign addr_ok = paddr == PMC_CTRL_OFS || paddr == PMC_STAT_OFS ||
                   paddr == PMC_IRQ_OFS || paddr == PMC_MASK_OFS ||
                   paddr == PMC_ANALOG_OFS;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // pad and clock controls
  logic in_pd;
  assign in_pd = (mode_r == PMC_PDOWN);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      core_clk_en    <= 1'b0;
      periph_clk_en  <= 1'b0;
      osc_en         <= 1'b1;
      pin_hold       <= 1'b0;
      analog_out_hiz <= 1'b1;
      chip_reset     <= 1'b1;
      analog_en      <= '0;
    end else begin
      chip_reset     <= soft_rst;
      core_clk_en    <= !soft_rst && mode_r == PMC_RUN;
      periph_clk_en  <= !soft_rst && !in_pd && mode_r != PMC_SETTLE;
      osc_en         <= !in_pd;
      pin_hold       <= mode_r != PMC_RUN;
      analog_out_hiz <= in_pd;
      analog_en.adc_en  <= !in_pd && ana_r[ANA_ADC_BIT];
      analog_en.dac0_en <= !in_pd && ana_r[ANA_DAC0_BIT];
      analog_en.dac1_en <= !in_pd && ana_r[ANA_DAC1_BIT];
      analog_en.vref_en <= !in_pd && ana_r[ANA_VREF_BIT];
    end
  end

  assign resume_after_pd = resume_r;

endmodule

// ===== verification/pmc_props.sv
// Purpose: port-level checks of the power mode controller
// Assumes: one clock domain, bound to pmc_top
// Notes:   wake enables sit in registers, so only unconditional wakes are checked
module pmc_props
  import pmc_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        ext_reset_n,
  input wire logic        supply_above_floor,
  input wire logic        interval_counter,
  input wire logic        return_from_interrupt,
  input wire logic        core_clk_en,
  input wire logic        periph_clk_en,
  input wire logic        osc_en,
  input wire logic        pin_hold,
  input wire logic        analog_out_hiz,
  input wire logic        chip_reset,
  input wire logic        resume_after_pd,
  input wire pmc_analog_t analog_en
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_idle_osc;
    periph_clk_en && !core_clk_en |-> osc_en;
  endproperty
  a_idle_osc: assert property (p_idle_osc) else $error("idle lost oscillator");
  property p_pd_stop;
    !osc_en |-> !periph_clk_en && !core_clk_en;
  endproperty
  a_pd_stop: assert property (p_pd_stop) else $error("clock live without osc");
  property p_pd_pins;
    !osc_en |-> analog_out_hiz && pin_hold && analog_en == '0;
  endproperty
  a_pd_pins: assert property (p_pd_pins) else $error("pads wrong in power-down");
  property p_ext_rst;
    !ext_reset_n [*4] |-> chip_reset;
  endproperty
  a_ext_rst: assert property (p_ext_rst) else $error("reset pin ignored");
  property p_core_rst;
    chip_reset [*2] |-> !core_clk_en;
  endproperty
  a_core_rst: assert property (p_core_rst) else $error("core clocked in reset");
  property p_floor;
    !supply_above_floor [*4] |=> chip_reset;
  endproperty
  a_floor: assert property (p_floor) else $error("no reset below floor");
  property p_settle;
    $rose(osc_en) && !chip_reset |-> !core_clk_en [*8];
  endproperty
  a_settle: assert property (p_settle) else $error("core clocked before settle");
  property p_tic;
    !osc_en && interval_counter |-> ##[1:4] osc_en;
  endproperty
  a_tic: assert property (p_tic) else $error("interval wake missed");
  property p_rfi;
    return_from_interrupt |=> !resume_after_pd;
  endproperty
  a_rfi: assert property (p_rfi) else $error("resume flag stuck");
endmodule

// ===== verification/pmc_top_tb.sv
// Purpose: self-checking bench for the power mode controller
// Assumes: POR count cut to 8 ticks; outputs sampled on the falling edge
// Notes:   wake sources are held until the oscillator restarts
module pmc_top_tb
  import pmc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, osc_tick = 0;
  logic        ext_reset_n = 1, supply_above_thr = 1, supply_above_floor = 1;
  logic        interval_counter = 0, serial_irq = 0, external_interrupt_zero = 0;
  logic        irq_enabled_any = 0, return_from_interrupt = 0, er;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, core_clk_en, periph_clk_en, osc_en, pin_hold;
  logic        analog_out_hiz, chip_reset, resume_after_pd, irq;
  pmc_analog_t analog_en;
  int          num_errors = 0, samples_checked = 0, n;

  always #5 clock = ~clock;
  always @(posedge clock) osc_tick <= ~osc_tick;

  pmc_top #(.POR_COUNT(8)) pmc_top_i (
    .clock (clock), .rst_n (rst_n), .psel (psel), .penable (penable),
    .pwrite (pwrite), .paddr (paddr), .pwdata (pwdata), .prdata (prdata),
    .pready (pready), .pslverr (pslverr), .ext_reset_n (ext_reset_n),
    .supply_above_thr (supply_above_thr), .supply_above_floor (supply_above_floor),
    .osc_tick (osc_tick), .interval_counter (interval_counter),
    .serial_irq (serial_irq), .external_interrupt_zero (external_interrupt_zero),
    .irq_enabled_any (irq_enabled_any), .return_from_interrupt (return_from_interrupt),
    .core_clk_en (core_clk_en), .periph_clk_en (periph_clk_en), .osc_en (osc_en),
    .pin_hold (pin_hold), .analog_out_hiz (analog_out_hiz), .chip_reset (chip_reset),
    .resume_after_pd (resume_after_pd), .analog_en (analog_en), .irq (irq)
  );

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // answer is taken at the rising edge where pready is seen high
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    conclude();
  end

  initial begin
    logic [7:0]  ofs [4];
    logic [31:0] rv [4];
    ofs = '{PMC_CTRL_OFS, PMC_MASK_OFS, PMC_ANALOG_OFS, PMC_IRQ_OFS};
    rv = '{32'h0, 32'h0, 32'h0, 32'h8};
    cyc(12);
    chk({chip_reset, osc_en, core_clk_en}, 3'b110);
    @(posedge clock) rst_n <= 1'b1;
    for (n = 0; n < 300 && chip_reset !== 1'b0; n++) cyc(1);
    cyc(3);
    chk(core_clk_en, 1);
    foreach (ofs[i]) begin
      xfer(0, ofs[i], 0);
      chk(rd, rv[i]);
    end
    xfer(0, 8'h14, 0);
    chk({pready, er, rd}, 34'h300000000);
    for (int i = 0; i < 4; i++) begin
      xfer(1, PMC_ANALOG_OFS, 32'h1 << i);
      xfer(0, PMC_ANALOG_OFS, 0);
      chk(rd, 32'h1 << i);
      chk(analog_en, 32'h8 >> i);
    end
    $display("reset and analog test done");
    xfer(1, PMC_MASK_OFS, 32'h2);
    xfer(1, PMC_CTRL_OFS, 32'h1);
    cyc(3);
    chk({core_clk_en, periph_clk_en, osc_en, analog_out_hiz, analog_en}, 8'h61);
    @(posedge clock) irq_enabled_any <= 1'b1;
    for (n = 0; n < 20 && core_clk_en !== 1'b1; n++) cyc(1);
    @(posedge clock) irq_enabled_any <= 1'b0;
    chk(core_clk_en, 1);
    xfer(0, PMC_IRQ_OFS, 0);
    cyc(1);
    chk({irq, rd}, 33'h1);
    $display("idle test done");
    xfer(1, PMC_CTRL_OFS, 32'h2);
    cyc(3);
    chk({core_clk_en, periph_clk_en, osc_en, analog_out_hiz, pin_hold}, 5'h3);
    chk(analog_en, 0);
    @(posedge clock) interval_counter <= 1'b1;
    for (n = 0; n < 20 && osc_en !== 1'b1; n++) cyc(1);
    @(posedge clock) interval_counter <= 1'b0;
    for (n = 0; n < 1200 && core_clk_en !== 1'b1; n++) cyc(1);
    chk(n > OSC_CYCLES - 10 && core_clk_en === 1'b1, 1);
    chk({resume_after_pd, irq}, 2'b11);
    xfer(0, PMC_IRQ_OFS, 0);
    cyc(1);
    chk({irq, rd}, 33'h2);
    @(posedge clock) return_from_interrupt <= 1'b1;
    @(posedge clock) return_from_interrupt <= 1'b0;
    cyc(1);
    chk(resume_after_pd, 0);
    for (int k = 0; k < 2; k++) begin
      xfer(1, PMC_CTRL_OFS, 32'h2);
      @(posedge clock) {external_interrupt_zero, serial_irq} <= 2'b01 << k;
      cyc(20);
      chk(osc_en, 0);
      @(posedge clock) {external_interrupt_zero, serial_irq} <= 2'b00;
      xfer(1, PMC_CTRL_OFS, 32'h4 << k);
      @(posedge clock) {external_interrupt_zero, serial_irq} <= 2'b01 << k;
      for (n = 0; n < 20 && osc_en !== 1'b1; n++) cyc(1);
      @(posedge clock) {external_interrupt_zero, serial_irq} <= 2'b00;
      chk(osc_en, 1);
      for (n = 0; n < 1200 && core_clk_en !== 1'b1; n++) cyc(1);
    end
    $display("power-down wake test done");
    xfer(1, PMC_ANALOG_OFS, 32'h8);
    xfer(1, PMC_CTRL_OFS, 32'h2);
    cyc(3);
    @(posedge clock) ext_reset_n <= 1'b0;
    cyc(6);
    chk({chip_reset, osc_en}, 2'b11);
    @(posedge clock) ext_reset_n <= 1'b1;
    for (n = 0; n < 300 && chip_reset !== 1'b0; n++) cyc(1);
    xfer(0, PMC_ANALOG_OFS, 0);
    chk({chip_reset, rd}, 33'h0);
    @(posedge clock) supply_above_thr <= 1'b0;
    cyc(6);
    chk(chip_reset, 1);
    @(posedge clock) {supply_above_thr, supply_above_floor} <= 2'b00;
    cyc(6);
    chk(chip_reset, 1);
    @(posedge clock) supply_above_floor <= 1'b1;
    cyc(40);
    chk(chip_reset, 1);
    @(posedge clock) supply_above_thr <= 1'b1;
    for (n = 0; n < 300 && chip_reset !== 1'b0; n++) cyc(1);
    chk(chip_reset === 1'b0 && n >= 8, 1);
    $display("reset source test done");
    conclude();
  end
endmodule

bind pmc_top pmc_props pmc_props_i (
  .clock                 (clock),
  .rst_n                 (rst_n),
  .ext_reset_n           (ext_reset_n),
  .supply_above_floor    (supply_above_floor),
  .interval_counter      (interval_counter),
  .return_from_interrupt (return_from_interrupt),
  .core_clk_en           (core_clk_en),
  .periph_clk_en         (periph_clk_en),
  .osc_en                (osc_en),
  .pin_hold              (pin_hold),
  .analog_out_hiz        (analog_out_hiz),
  .chip_reset            (chip_reset),
  .resume_after_pd       (resume_after_pd),
  .analog_en             (analog_en)
);
